// ### src/event_router_defines.vh
`ifndef EVENT_ROUTER_DEFINES_VH
`define EVENT_ROUTER_DEFINES_VH

// Register offsets.
`define ADDR_ASYNC_CHANNEL_STROBE  8'h00
`define ADDR_SYNC_CHANNEL_STROBE   8'h01
`define ADDR_ASYNC_SOURCE_SELECT_0 8'h02
`define ADDR_ASYNC_SOURCE_SELECT_1 8'h03
`define ADDR_SYNC_SOURCE_SELECT_0  8'h0A
`define ADDR_ASYNC_USER_SELECT_0   8'h12
`define ADDR_ASYNC_USER_SELECT_1   8'h13
`define ADDR_ASYNC_USER_SELECT_2   8'h14
`define ADDR_ASYNC_USER_SELECT_3   8'h15
`define ADDR_ASYNC_USER_SELECT_4   8'h16
`define ADDR_ASYNC_USER_SELECT_5   8'h17
`define ADDR_ASYNC_USER_SELECT_6   8'h18
`define ADDR_ASYNC_USER_SELECT_7   8'h19
`define ADDR_ASYNC_USER_SELECT_8   8'h1A
`define ADDR_ASYNC_USER_SELECT_9   8'h1B
`define ADDR_ASYNC_USER_SELECT_10  8'h1C
`define ADDR_SYNC_USER_SELECT_0    8'h22
`define ADDR_SYNC_USER_SELECT_1    8'h23

// Reset value shared by every register.
`define REG_RESET                  8'h00

// Counts.
`define NUM_ASYNC_USERS            11
`define NUM_SYNC_USERS             2

// Asynchronous channel source codes.
`define ASRC_OFF                   8'h00
`define ASRC_LUT0                  8'h01
`define ASRC_LUT1                  8'h02
`define ASRC_COMPARATOR            8'h03
`define ASRC_COUNTER_OVF           8'h08
`define ASRC_COUNTER_CMP           8'h09
`define ASRC_PIN_FIRST             8'h0A
`define ASRC_PIN_LAST              8'h11
`define ASRC_DEBUG                 8'h12

// Synchronous channel source codes.
`define SSRC_OFF                   8'h00
`define SSRC_TIMER_B               8'h01
`define SSRC_TIMER_A_OVF_LUNF      8'h02
`define SSRC_TIMER_A_HUNF          8'h03
`define SSRC_TIMER_A_CMP_FIRST     8'h04
`define SSRC_TIMER_A_CMP_LAST      8'h06
`define SSRC_PORT_C_FIRST          8'h07
`define SSRC_PORT_C_LAST           8'h0C
`define SSRC_PORT_A_FIRST          8'h0D
`define SSRC_PORT_A_LAST           8'h14

// User multiplexer codes.
`define USEL_OFF                   8'h00
`define USEL_SYNC_0                8'h01
`define USEL_ASYNC_0               8'h03
`define USEL_ASYNC_1               8'h04

// Strobe bit positions.
`define STROBE_CH0                 0
`define STROBE_CH1                 1

`endif

// ### src/async_source_mux.v
`timescale 1ns/1ps
`include "event_router_defines.vh"

module async_source_mux #(
  parameter HAS_DEBUG = 0
) (
  // Selection.
  input  wire [7:0] code_i,
  // Generators.
  input  wire       lut0_i,
  input  wire       lut1_i,
  input  wire       comparator_i,
  input  wire       counter_ovf_i,
  input  wire       counter_cmp_i,
  input  wire [7:0] pins_i,
  input  wire       debug_i,
  // Channel.
  output reg        event_o
);

  wire [7:0] pin_index;

  assign pin_index = code_i - `ASRC_PIN_FIRST;

  // Pure gates only, so the path keeps working with the clock stopped.
  always @* begin
    event_o = 1'b0;
    if (code_i == `ASRC_LUT0) begin
      event_o = lut0_i;
    end else if (code_i == `ASRC_LUT1) begin
      event_o = lut1_i;
    end else if (code_i == `ASRC_COMPARATOR) begin
      event_o = comparator_i;
    end else if (code_i == `ASRC_COUNTER_OVF) begin
      event_o = counter_ovf_i;
    end else if (code_i == `ASRC_COUNTER_CMP) begin
      event_o = counter_cmp_i;
    end else if (code_i >= `ASRC_PIN_FIRST && code_i <= `ASRC_PIN_LAST) begin
      event_o = pins_i[pin_index[2:0]];
    end else if (HAS_DEBUG != 0 && code_i == `ASRC_DEBUG) begin
      event_o = debug_i;
    end
  end

endmodule // async_source_mux

// ### src/user_mux.v
`timescale 1ns/1ps
`include "event_router_defines.vh"

module user_mux #(
  parameter ASYNC_OK = 1
) (
  // Selection.
  input  wire [7:0] code_i,
  // Channels.
  input  wire       sync_ch0_i,
  input  wire       async_ch0_i,
  input  wire       async_ch1_i,
  // User event.
  output reg        event_o
);

  always @* begin
    event_o = 1'b0;
    if (code_i == `USEL_SYNC_0) begin
      event_o = sync_ch0_i;
    end else if (ASYNC_OK != 0 && code_i == `USEL_ASYNC_0) begin
      event_o = async_ch0_i;
    end else if (ASYNC_OK != 0 && code_i == `USEL_ASYNC_1) begin
      event_o = async_ch1_i;
    end
  end

endmodule // user_mux

// ### src/event_router.v
// Behaviour
// - Writing a strobe register inverts each addressed channel for one clock cycle.
// - Async selectors decode off, lookups, comparator, counter events and port pins.
// - Async channel 0 also takes the debug event; other codes are reserved.
// - Sync channel 0 decodes timer events, port C and port A pins.
// - Eleven async-capable users: timer B, converter, lookups, reserved, pins.
// - Async-capable users decode off, sync channel 0, async channels 0 and 1.
// - Two sync-only users, timer A and serial port, decode off or sync 0.
// - Async routing works without clock; strobes need the clock running.
// - A channel event is a one-cycle pulse or a level, per generator.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "event_router_defines.vh"

module event_router (
  // Clock and reset.
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  // Register port.
  input  wire [7:0] addr_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_en_i,
  input  wire       rd_en_i,
  output reg  [7:0] rd_data_o,
  // Asynchronous generators.
  input  wire       logic_lookup_zero_out_i,
  input  wire       logic_lookup_one_out_i,
  input  wire       comparator_output_i,
  input  wire       counter_overflow_event_i,
  input  wire       counter_compare_event_i,
  input  wire [7:0] port_a_pin_i,
  input  wire [7:0] port_b_pin_i,
  input  wire       debug_interface_event_i,
  // Synchronous generators.
  input  wire       timer_b_event_i,
  input  wire       timer_a_overflow_low_underflow_i,
  input  wire       timer_a_high_underflow_i,
  input  wire [2:0] timer_a_compare_i,
  input  wire [5:0] port_c_pin_i,
  // Async-capable users.
  output wire       timer_b_user_o,
  output wire       converter_user_o,
  output wire [3:0] lookup_event_o,
  output wire [2:0] event_pin_output_o,
  // Sync-only users.
  output wire       timer_a_user_o,
  output wire       serial_user_o
);

  // Stored registers.
  reg  [7:0] async_channel_strobe;
  reg  [7:0] sync_channel_strobe;
  reg  [7:0] async_source_select_0;
  reg  [7:0] async_source_select_1;
  reg  [7:0] sync_source_select_0;
  reg  [7:0] async_user_select [0:`NUM_ASYNC_USERS-1];
  reg  [7:0] sync_user_select  [0:`NUM_SYNC_USERS-1];

  // One-cycle strobe pulses.
  reg  [7:0] async_pulse;
  reg  [7:0] sync_pulse;

  // Read path.
  reg  [7:0] next_rd_data;
  wire [7:0] user_index;

  // Channels.
  wire       async_raw_0;
  wire       async_raw_1;
  reg        sync_raw_0;
  wire       async_ch_0;
  wire       async_ch_1;
  wire       sync_ch_0;
  wire [7:0] sync_c_index;
  wire [7:0] sync_a_index;
  wire [7:0] sync_cmp_index;

  // User outputs.
  wire [`NUM_ASYNC_USERS-1:0] async_user_event;
  wire [`NUM_SYNC_USERS-1:0]  sync_user_event;

  wire       write_async_user;
  wire       write_sync_user;

  // Async user writes are decoded by distance from user 0, sync users by the
  // lowest offset bit, which keeps the per-user logic inside one loop.
  assign user_index       = addr_i - `ADDR_ASYNC_USER_SELECT_0;
  assign write_async_user = wr_en_i &&
                            addr_i >= `ADDR_ASYNC_USER_SELECT_0 &&
                            addr_i <= `ADDR_ASYNC_USER_SELECT_10;
  assign write_sync_user  = wr_en_i &&
                            (addr_i == `ADDR_SYNC_USER_SELECT_0 ||
                             addr_i == `ADDR_SYNC_USER_SELECT_1);

  // Channel and selector registers.
  // Strobe registers only keep the value for read-back; the pulse below acts.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      async_channel_strobe  <= `REG_RESET;
      sync_channel_strobe   <= `REG_RESET;
      async_source_select_0 <= `REG_RESET;
      async_source_select_1 <= `REG_RESET;
      sync_source_select_0  <= `REG_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        `ADDR_ASYNC_CHANNEL_STROBE: begin
          async_channel_strobe <= wr_data_i;
        end
        `ADDR_SYNC_CHANNEL_STROBE: begin
          sync_channel_strobe <= wr_data_i;
        end
        `ADDR_ASYNC_SOURCE_SELECT_0: begin
          async_source_select_0 <= wr_data_i;
        end
        `ADDR_ASYNC_SOURCE_SELECT_1: begin
          async_source_select_1 <= wr_data_i;
        end
        `ADDR_SYNC_SOURCE_SELECT_0: begin
          sync_source_select_0 <= wr_data_i;
        end
        default: begin
          async_channel_strobe <= async_channel_strobe;
        end
      endcase
    end
  end

  // The pulse lives for exactly the cycle after the write. Since it is
  // clocked, a halted peripheral clock can never launch one.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      async_pulse <= `REG_RESET;
      sync_pulse  <= `REG_RESET;
    end else begin
      async_pulse <= (wr_en_i && addr_i == `ADDR_ASYNC_CHANNEL_STROBE) ?
                     wr_data_i : `REG_RESET;
      sync_pulse  <= (wr_en_i && addr_i == `ADDR_SYNC_CHANNEL_STROBE) ?
                     wr_data_i : `REG_RESET;
    end
  end

  // User selector registers, one per multiplexer.
  // Users 6 and 7 are reserved: their selectors are stored and read back,
  // but their multiplexer outputs feed no port.
  genvar u;
  generate
    for (u = 0; u < `NUM_ASYNC_USERS; u = u + 1) begin : g_async_user
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          async_user_select[u] <= `REG_RESET;
        end else if (write_async_user && user_index == u) begin
          async_user_select[u] <= wr_data_i;
        end
      end

      user_mux #(
        .ASYNC_OK (1)
      ) u_user_mux (
        .code_i      (async_user_select[u]),
        .sync_ch0_i  (sync_ch_0),
        .async_ch0_i (async_ch_0),
        .async_ch1_i (async_ch_1),
        .event_o     (async_user_event[u])
      );
    end

    for (u = 0; u < `NUM_SYNC_USERS; u = u + 1) begin : g_sync_user
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync_user_select[u] <= `REG_RESET;
        end else if (write_sync_user && addr_i[0] == u) begin
          sync_user_select[u] <= wr_data_i;
        end
      end

      // Async channels are kept away from users that cannot synchronise them.
      user_mux #(
        .ASYNC_OK (0)
      ) u_user_mux (
        .code_i      (sync_user_select[u]),
        .sync_ch0_i  (sync_ch_0),
        .async_ch0_i (1'b0),
        .async_ch1_i (1'b0),
        .event_o     (sync_user_event[u])
      );
    end
  endgenerate

  // Read decode; unmapped offsets read as zero.
  always @* begin
    next_rd_data = `REG_RESET;
    case (addr_i)
      // Strobe registers read back the last value written.
      `ADDR_ASYNC_CHANNEL_STROBE: begin
        next_rd_data = async_channel_strobe;
      end
      `ADDR_SYNC_CHANNEL_STROBE: begin
        next_rd_data = sync_channel_strobe;
      end

      // Channel source selectors.
      `ADDR_ASYNC_SOURCE_SELECT_0: begin
        next_rd_data = async_source_select_0;
      end
      `ADDR_ASYNC_SOURCE_SELECT_1: begin
        next_rd_data = async_source_select_1;
      end
      `ADDR_SYNC_SOURCE_SELECT_0: begin
        next_rd_data = sync_source_select_0;
      end

      // Async-capable user selectors, reserved users included.
      `ADDR_ASYNC_USER_SELECT_0: begin
        next_rd_data = async_user_select[0];
      end
      `ADDR_ASYNC_USER_SELECT_1: begin
        next_rd_data = async_user_select[1];
      end
      `ADDR_ASYNC_USER_SELECT_2: begin
        next_rd_data = async_user_select[2];
      end
      `ADDR_ASYNC_USER_SELECT_3: begin
        next_rd_data = async_user_select[3];
      end
      `ADDR_ASYNC_USER_SELECT_4: begin
        next_rd_data = async_user_select[4];
      end
      `ADDR_ASYNC_USER_SELECT_5: begin
        next_rd_data = async_user_select[5];
      end
      `ADDR_ASYNC_USER_SELECT_6: begin
        next_rd_data = async_user_select[6];
      end
      `ADDR_ASYNC_USER_SELECT_7: begin
        next_rd_data = async_user_select[7];
      end
      `ADDR_ASYNC_USER_SELECT_8: begin
        next_rd_data = async_user_select[8];
      end
      `ADDR_ASYNC_USER_SELECT_9: begin
        next_rd_data = async_user_select[9];
      end
      `ADDR_ASYNC_USER_SELECT_10: begin
        next_rd_data = async_user_select[10];
      end

      // Sync-only user selectors.
      `ADDR_SYNC_USER_SELECT_0: begin
        next_rd_data = sync_user_select[0];
      end
      `ADDR_SYNC_USER_SELECT_1: begin
        next_rd_data = sync_user_select[1];
      end
      default: begin
        next_rd_data = `REG_RESET;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `REG_RESET;
    end else if (rd_en_i) begin
      rd_data_o <= next_rd_data;
    end else begin
      rd_data_o <= `REG_RESET;
    end
  end

  // Asynchronous channel sources.
  // Channel 1 has no debug source, so its debug input is tied low.
  async_source_mux #(
    .HAS_DEBUG (1)
  ) u_async_src_0 (
    .code_i        (async_source_select_0),
    .lut0_i        (logic_lookup_zero_out_i),
    .lut1_i        (logic_lookup_one_out_i),
    .comparator_i  (comparator_output_i),
    .counter_ovf_i (counter_overflow_event_i),
    .counter_cmp_i (counter_compare_event_i),
    .pins_i        (port_a_pin_i),
    .debug_i       (debug_interface_event_i),
    .event_o       (async_raw_0)
  );

  async_source_mux #(
    .HAS_DEBUG (0)
  ) u_async_src_1 (
    .code_i        (async_source_select_1),
    .lut0_i        (logic_lookup_zero_out_i),
    .lut1_i        (logic_lookup_one_out_i),
    .comparator_i  (comparator_output_i),
    .counter_ovf_i (counter_overflow_event_i),
    .counter_cmp_i (counter_compare_event_i),
    .pins_i        (port_b_pin_i),
    .debug_i       (1'b0),
    .event_o       (async_raw_1)
  );

  // Synchronous channel source.
  // Compare channels and pins are indexed by the code's distance from the
  // first code of their range; only the low bits of each index are needed.
  assign sync_c_index   = sync_source_select_0 - `SSRC_PORT_C_FIRST;
  assign sync_a_index   = sync_source_select_0 - `SSRC_PORT_A_FIRST;
  assign sync_cmp_index = sync_source_select_0 - `SSRC_TIMER_A_CMP_FIRST;

  always @* begin
    sync_raw_0 = 1'b0;
    if (sync_source_select_0 == `SSRC_TIMER_B) begin
      sync_raw_0 = timer_b_event_i;
    end else if (sync_source_select_0 == `SSRC_TIMER_A_OVF_LUNF) begin
      sync_raw_0 = timer_a_overflow_low_underflow_i;
    end else if (sync_source_select_0 == `SSRC_TIMER_A_HUNF) begin
      sync_raw_0 = timer_a_high_underflow_i;
    end else if (sync_source_select_0 >= `SSRC_TIMER_A_CMP_FIRST &&
                 sync_source_select_0 <= `SSRC_TIMER_A_CMP_LAST) begin
      sync_raw_0 = timer_a_compare_i[sync_cmp_index[1:0]];
    end else if (sync_source_select_0 >= `SSRC_PORT_C_FIRST &&
                 sync_source_select_0 <= `SSRC_PORT_C_LAST) begin
      sync_raw_0 = port_c_pin_i[sync_c_index[2:0]];
    end else if (sync_source_select_0 >= `SSRC_PORT_A_FIRST &&
                 sync_source_select_0 <= `SSRC_PORT_A_LAST) begin
      sync_raw_0 = port_a_pin_i[sync_a_index[2:0]];
    end
  end

  // The strobe inverts whatever the channel carries, so a pulse or level from
  // the generator passes through unchanged outside the strobe cycle.
  assign async_ch_0 = async_raw_0 ^ async_pulse[`STROBE_CH0];
  assign async_ch_1 = async_raw_1 ^ async_pulse[`STROBE_CH1];
  assign sync_ch_0  = sync_raw_0  ^ sync_pulse[`STROBE_CH0];

  // Async user outputs are combinational so they route without a clock.
  assign timer_b_user_o     = async_user_event[0];
  assign converter_user_o   = async_user_event[1];
  assign lookup_event_o     = async_user_event[5:2];
  assign event_pin_output_o = async_user_event[10:8];
  assign timer_a_user_o     = sync_user_event[0];
  assign serial_user_o      = sync_user_event[1];

endmodule // event_router

// ### dv/event_generators_model.sv
`timescale 1ns/1ps
module event_generators_model (
  // Clock.
  input  wire        ref_clk_i,
  // Generator activity asked for by the bench.
  input  wire [33:0] gen_i,
  input  wire        slow_i,
  // Generator outputs.
  output wire [33:0] gen_o
);
  reg [11:0] stage1;
  reg [11:0] stage2;
  // Clocked generators answer one or, when slow, two cycles after the request.
  always @(posedge ref_clk_i) begin
    stage1 <= gen_i[17:6];
    stage2 <= stage1;
  end
  // Unclocked generators keep signalling while the clock is halted.
  assign gen_o[5:0]   = gen_i[5:0];
  assign gen_o[17:6]  = slow_i ? stage2 : stage1;
  assign gen_o[33:18] = gen_i[33:18];
endmodule // event_generators_model

// ### dv/event_router_checker.sv
`timescale 1ns/1ps
module event_router_checker (
  input wire       ref_clk_i,
  input wire       rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire       wr_en_i,
  input wire       rd_en_i,
  input wire [7:0] rd_data_o,
  input wire       comparator_output_i,
  input wire       debug_interface_event_i,
  input wire       timer_b_user_o,
  input wire       timer_a_user_o
);
  reg [7:0] src0;
  reg [7:0] usr0;
  reg [7:0] ssrc0;
  reg [7:0] susr0;
  reg       pend_a;
  // Shadows of the selectors, rebuilt from bus writes.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src0 <= 8'h00;
      usr0 <= 8'h00;
      ssrc0 <= 8'h00;
      susr0 <= 8'h00;
      pend_a <= 1'b0;
    end else begin
      pend_a <= wr_en_i && addr_i == 8'h00 && wr_data_i[0];
      if (wr_en_i && addr_i == 8'h02) src0 <= wr_data_i;
      if (wr_en_i && addr_i == 8'h12) usr0 <= wr_data_i;
      if (wr_en_i && addr_i == 8'h0A) ssrc0 <= wr_data_i;
      if (wr_en_i && addr_i == 8'h22) susr0 <= wr_data_i;
    end
  end
  // A pending strobe flips the channel, so plain routing is only judged outside it.
  wire route_a = usr0 == 8'h03 && !pend_a;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence one_pulse(sig);
    sig ##1 !sig;
  endsequence
  a_read_idle_zero:
    assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00) else $error("read data not idle");
  a_read_user_zero:
    assert property (rd_en_i && addr_i == 8'h12 |=> rd_data_o == $past(usr0))
      else $error("user select read back wrong");
  a_async_strobe_pulse:
    assert property (wr_en_i && addr_i == 8'h00 && wr_data_i[0] && src0 == 8'h00 && usr0 == 8'h03
      |=> one_pulse(timer_b_user_o)) else $error("async strobe pulse wrong");
  a_sync_strobe_pulse:
    assert property (wr_en_i && addr_i == 8'h01 && wr_data_i[0] && ssrc0 == 8'h00
      && susr0 == 8'h01 |=> one_pulse(timer_a_user_o)) else $error("sync strobe pulse wrong");
  a_user_off_quiet:
    assert property (usr0 == 8'h00 |-> !timer_b_user_o) else $error("user off not quiet");
  a_comp_route_async:
    assert property (route_a && src0 == 8'h03 |-> timer_b_user_o == comparator_output_i)
      else $error("comparator route wrong");
  a_debug_route_async:
    assert property (route_a && src0 == 8'h12 |-> timer_b_user_o == debug_interface_event_i)
      else $error("debug route wrong");
  a_reserved_code_quiet:
    assert property (route_a && src0 == 8'h05 |-> !timer_b_user_o)
      else $error("reserved code not quiet");
  a_sync_user_only:
    assert property (susr0 == 8'h03 |-> !timer_a_user_o) else $error("sync user took async");
endmodule // event_router_checker

bind event_router event_router_checker u_event_router_checker (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
  .comparator_output_i(comparator_output_i), .debug_interface_event_i(debug_interface_event_i),
  .timer_b_user_o(timer_b_user_o), .timer_a_user_o(timer_a_user_o));

// ### dv/event_router_tb.sv
`timescale 1ns/1ps
module event_router_tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         run = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [7:0]  wdat = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [33:0] gen = 34'h0;
  reg         slow = 1'b0;
  wire [7:0]  rdat;
  wire [33:0] g;
  wire        tb_u;
  wire        cv_u;
  wire        ta_u;
  wire        se_u;
  wire [3:0]  lk;
  wire [2:0]  ep;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     i;
  reg  [31:0] row;
  reg  [31:0] rows [0:24];

  // Halting the clock stands for a sleep mode without a peripheral clock.
  initial forever #5 if (run) ref_clk = ~ref_clk;

  event_generators_model u_event_generators_model (.ref_clk_i(ref_clk), .gen_i(gen),
    .slow_i(slow), .gen_o(g));
  event_router u_event_router (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr),
    .wr_data_i(wdat), .wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdat),
    .logic_lookup_zero_out_i(g[0]), .logic_lookup_one_out_i(g[1]),
    .comparator_output_i(g[2]), .counter_overflow_event_i(g[3]),
    .counter_compare_event_i(g[4]), .debug_interface_event_i(g[5]),
    .timer_b_event_i(g[6]), .timer_a_overflow_low_underflow_i(g[7]),
    .timer_a_high_underflow_i(g[8]), .timer_a_compare_i(g[11:9]), .port_c_pin_i(g[17:12]),
    .port_a_pin_i(g[25:18]), .port_b_pin_i(g[33:26]), .timer_b_user_o(tb_u),
    .converter_user_o(cv_u), .lookup_event_o(lk), .event_pin_output_o(ep),
    .timer_a_user_o(ta_u), .serial_user_o(se_u));

  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task wreg(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
    end
  endtask

  task rchk(input [7:0] a, input [7:0] exp);
    begin
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 check("rd_data", rdat, exp);
    end
  endtask

  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  initial begin
    #300000;
    fails = fails + 1;
    complete_run;
  end

  // Row: selector offset, code, generator bit to raise (FF raises all), expected user level.
  initial begin
    rows[0] = 32'h0200FF00; rows[1] = 32'h02010001; rows[2] = 32'h02020101;
    rows[3] = 32'h02030201; rows[4] = 32'h0205FF00; rows[5] = 32'h02080301;
    rows[6] = 32'h02090401; rows[7] = 32'h020A1201; rows[8] = 32'h02111901;
    rows[9] = 32'h02120501; rows[10] = 32'h0213FF00; rows[11] = 32'h030A1A01;
    rows[12] = 32'h03112101; rows[13] = 32'h0312FF00; rows[14] = 32'h03090401;
    rows[15] = 32'h0A010601; rows[16] = 32'h0A020701; rows[17] = 32'h0A030801;
    rows[18] = 32'h0A040901; rows[19] = 32'h0A060B01; rows[20] = 32'h0A070C01;
    rows[21] = 32'h0A0C1101; rows[22] = 32'h0A0D1201; rows[23] = 32'h0A141901;
    rows[24] = 32'h0A15FF00;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 36; i = i + 1) rchk(i[7:0], 8'h00);
    check("timer_b_user", tb_u, 8'h00);
    wreg(8'h12, 8'h03);
    wreg(8'h13, 8'h04);
    wreg(8'h14, 8'h01);
    wreg(8'h22, 8'h01);
    for (i = 0; i < 25; i = i + 1) begin
      row = rows[i];
      wreg(row[31:24], row[23:16]);
      slow <= (i >= 15);
      gen <= (row[15:8] == 8'hFF) ? {34{1'b1}} : (34'h1 << row[15:8]);
      repeat (4) @(posedge ref_clk);
      #1;
      check("routed", row[31:24] == 8'h02 ? tb_u : row[31:24] == 8'h03 ? cv_u : lk[0],
        row[7:0]);
      if (row[31:24] == 8'h0A) check("sync_user", ta_u, row[7:0]);
    end
    gen <= 34'h0;
    wreg(8'h02, 8'h00);
    wreg(8'h0A, 8'h00);
    wreg(8'h00, 8'h03);
    #1 check("strobe_pulse", {cv_u, tb_u}, 8'h03);
    @(posedge ref_clk);
    #1 check("strobe_end", {cv_u, tb_u}, 8'h00);
    rchk(8'h00, 8'h03);
    wreg(8'h02, 8'h03);
    gen <= 34'h4;
    wreg(8'h00, 8'h01);
    #1 check("strobe_invert", tb_u, 8'h00);
    @(posedge ref_clk);
    #1 check("strobe_restore", tb_u, 8'h01);
    wreg(8'h01, 8'h01);
    #1 check("sync_strobe", ta_u, 8'h01);
    @(posedge ref_clk);
    #1 check("sync_strobe_end", ta_u, 8'h00);
    rchk(8'h01, 8'h01);
    for (i = 0; i < 11; i = i + 1) wreg(8'h12 + i[7:0], 8'h03);
    #1 check("all_users", {lk, cv_u, tb_u}, 8'h3F);
    check("all_pins", ep, 8'h07);
    rchk(8'h18, 8'h03);
    rchk(8'h19, 8'h03);
    wreg(8'h03, 8'h00);
    wreg(8'h1A, 8'h04);
    #1 check("event_pins", ep, 8'h06);
    wreg(8'h22, 8'h03);
    wreg(8'h0A, 8'h01);
    wreg(8'h23, 8'h01);
    gen <= 34'h44;
    repeat (4) @(posedge ref_clk);
    #1 check("sync_only_users", {se_u, ta_u}, 8'h02);
    @(negedge ref_clk);
    run = 1'b0;
    gen <= 34'h0;
    #20 check("clockless_low", ep[1], 8'h00);
    gen <= 34'h4;
    #20 check("clockless_high", ep[1], 8'h01);
    run = 1'b1;
    repeat (2) @(posedge ref_clk);
    // A reset in mid-run must turn every selector off at once.
    rst_n <= 1'b0;
    #1 check("reset_users", {lk, cv_u, tb_u}, 8'h00);
    check("reset_sync_users", {ep, se_u, ta_u}, 8'h00);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(8'h12, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h22, 8'h00);
    check("reset_route", ep, 8'h00);
    complete_run;
  end
endmodule // event_router_tb
